// ---- dram_cmd_pkg.sv ----
package dram_cmd_pkg;

    localparam int ADDR_W    = 21;          // address balls A0..A20
    localparam int BANK_W    = 3;
    localparam int BANKS     = 8;
    localparam int ROW_W     = 13;          // rows per bank counter
    localparam int CFG_W     = 3;
    localparam int LAT_W     = 4;
    localparam int PIPE_W    = 16;          // longest latency plus burst
    localparam int CFG_COUNT = 5;

    // mode word field positions
    localparam int CFG_LSB   = 0;
    localparam int BURST_LSB = 3;
    localparam int BURST_W   = 2;
    localparam int MUX_BIT   = 5;
    localparam int TERM_BIT  = 9;

    // reset values of the mode word
    localparam logic [CFG_W-1:0] CFG_RESET  = 3'h0;
    localparam logic             MUX_RESET  = 1'h0;
    localparam logic             TERM_RESET = 1'h0;

    // multiplexed address mapping
    localparam int FIRST_COUNT  = 11;
    localparam int SECOND_COUNT = 8;
    localparam int FIRST_BITS  [FIRST_COUNT]  = '{0, 3, 4, 5, 8, 9, 10, 13, 14, 17, 18};
    localparam int SECOND_BITS [SECOND_COUNT] = '{1, 2, 6, 7, 11, 12, 16, 15};
    localparam int SECOND_BALLS[SECOND_COUNT] = '{3, 4, 8, 9, 13, 14, 17, 18};
    localparam int BALL_A0  = 0;
    localparam int BALL_A10 = 10;
    localparam int BALL_A18 = 18;
    localparam int BIT_A19  = 19;
    localparam int BIT_A20  = 20;

    // normal-mode read latency per configuration, in clocks
    localparam logic [LAT_W-1:0] READ_LAT_TABLE[CFG_COUNT] = '{4'h4, 4'h6, 4'h8, 4'h3, 4'h5};
    localparam logic [LAT_W-1:0] LAT_ONE = 4'h1;

    // beat masks, one bit per clock of data
    localparam logic [PIPE_W-1:0] MASK_2 = 16'h0001;
    localparam logic [PIPE_W-1:0] MASK_4 = 16'h0003;
    localparam logic [PIPE_W-1:0] MASK_8 = 16'h000F;

    typedef enum logic [2:0] {NOP_CMD, READ_CMD, WRITE_CMD, ROW_REFRESH_CMD,
                              MODE_LOAD_CMD} cmd_kind_type;
    typedef enum logic [1:0] {BURST_2, BURST_4, BURST_8} burst_size_type;
    typedef enum logic [1:0] {WIDTH_X9, WIDTH_X18, WIDTH_X36} width_type;
    typedef enum logic {PHASE_IDLE, PHASE_SECOND} phase_type;

    typedef struct packed {
        logic chip_select_n;
        logic write_enable_n;
        logic refresh_n;
    } cmd_pins_type;

    typedef struct packed {
        logic              write;
        logic [BANK_W-1:0] bank;
        logic [ADDR_W-1:0] addr;
    } access_type;

    // command pin decode, shared by both address modes
    function automatic cmd_kind_type decode_cmd(input cmd_pins_type pins);
        cmd_kind_type kind;
        kind = NOP_CMD;
        if (!pins.chip_select_n) begin
            unique case ({pins.write_enable_n, pins.refresh_n})
                2'h3: kind = READ_CMD;
                2'h1: kind = WRITE_CMD;
                2'h2: kind = ROW_REFRESH_CMD;
                2'h0: kind = MODE_LOAD_CMD;
            endcase
        end
        return kind;
    endfunction : decode_cmd

    function automatic logic [LAT_W-1:0] read_lat(input logic [CFG_W-1:0] cfg);
        logic [LAT_W-1:0] lat;
        lat = READ_LAT_TABLE[0];
        if (int'(cfg) < CFG_COUNT) begin
            lat = READ_LAT_TABLE[cfg];
        end
        return lat;
    endfunction : read_lat

    function automatic logic [PIPE_W-1:0] beat_mask(input burst_size_type size);
        logic [PIPE_W-1:0] mask;
        unique case (size)
            BURST_4: mask = MASK_4;
            BURST_8: mask = MASK_8;
            default: mask = MASK_2;
        endcase
        return mask;
    endfunction : beat_mask

    // rebuild the full address from the two halves
    function automatic logic [ADDR_W-1:0] map_mux_addr(input logic [ADDR_W-1:0] first_addr_half,
                                                       input logic [ADDR_W-1:0] second_addr_half,
                                                       input width_type width,
                                                       input burst_size_type size);
        logic [ADDR_W-1:0] full;
        full = '0;
        for (int i = 0; i < FIRST_COUNT; i++) begin
            full[FIRST_BITS[i]] = first_addr_half[FIRST_BITS[i]];
        end
        for (int i = 0; i < SECOND_COUNT; i++) begin
            full[SECOND_BITS[i]] = second_addr_half[SECOND_BALLS[i]];
        end
        if ((width == WIDTH_X36 && size == BURST_4) || (width == WIDTH_X18 && size == BURST_8)) begin
            full[BALL_A18] = 1'h0;
        end
        if ((width == WIDTH_X18 && size == BURST_2) ||
            (width == WIDTH_X9 && (size == BURST_2 || size == BURST_4))) begin
            full[BIT_A19] = second_addr_half[BALL_A10];
        end
        if (width == WIDTH_X9 && size == BURST_2) begin
            full[BIT_A20] = second_addr_half[BALL_A0];
        end
        return full;
    endfunction : map_mux_addr

endpackage : dram_cmd_pkg

// ---- refresh_row_store.sv ----
module refresh_row_store
    import dram_cmd_pkg::*;
#(
    parameter int BANK_COUNT = BANKS,
    parameter int ROW_BITS   = ROW_W
) (
    input  wire logic                CLK,     // system clock
    input  wire logic                RST,     // synchronous reset, high
    input  wire logic                rd_en,   // fetch a bank counter
    input  wire logic [BANK_W-1:0]   rd_bank, // bank to fetch
    output      logic [ROW_BITS-1:0] rd_row,  // fetched row, registered
    input  wire logic                wr_en,   // store a bank counter
    input  wire logic [BANK_W-1:0]   wr_bank, // bank to store
    input  wire logic [ROW_BITS-1:0] wr_row   // value to store
);

    typedef struct packed {
        logic [BANK_COUNT-1:0][ROW_BITS-1:0] rows;
        logic [ROW_BITS-1:0]                 rd_row;
    } store_type;

    store_type s;
    store_type next_s;

    // one counter per bank, read data registered
    always_comb begin
        next_s = s;
        if (rd_en) begin
            next_s.rd_row = s.rows[rd_bank];
        end
        if (wr_en) begin
            next_s.rows[wr_bank] = wr_row;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rd_row = s.rd_row;

endmodule : refresh_row_store

// ---- dram_refresh_odt_mux_address.sv ----
module dram_refresh_odt_mux_address
    import dram_cmd_pkg::*;
(
    input  wire logic              CLK,               // command clock
    input  wire logic              RST,               // synchronous reset, high
    input  wire cmd_pins_type      CMD,               // command pins, low active
    input  wire logic [BANK_W-1:0] BANK,              // bank address balls
    input  wire logic [ADDR_W-1:0] ADDR,              // address balls
    input  wire width_type         WIDTH,             // data width of the part
    output      logic              REFRESH_STROBE,    // one row refreshed
    output      logic [BANK_W-1:0] REFRESH_BANK,      // bank refreshed
    output      logic [ROW_W-1:0]  REFRESH_ROW,       // row refreshed
    output      logic              ACCESS_STROBE,     // read or write issued
    output      access_type        ACCESS,            // issued access
    output      logic              MODE_LOAD_STROBE,  // mode word stored
    output      logic [CFG_W-1:0]  CONFIG,            // latency configuration
    output      burst_size_type    BURST_SIZE,        // programmed burst size
    output      logic              MUX_MODE,          // two-half addressing on
    output      logic [LAT_W-1:0]  READ_LATENCY,      // clocks from command
    output      logic [LAT_W-1:0]  WRITE_LATENCY,     // clocks from command
    output      logic              READ_DRIVE,        // device drives data bus
    output      logic              READ_VALID_FLAG,   // read data valid
    output      logic              WRITE_CAPTURE,     // write data captured
    output      logic              INPUT_TERMINATION  // data and mask termination
);

    typedef struct packed {
        phase_type         phase;
        logic [CFG_W-1:0]  cfg;
        burst_size_type    burst;
        logic              mux;
        logic              term_en;
        cmd_kind_type      held_cmd;
        logic [BANK_W-1:0] held_bank;
        logic [ADDR_W-1:0] first_half;
        logic              ref_pending;
        logic [BANK_W-1:0] ref_bank;
        logic              ref_rd;
        logic [BANK_W-1:0] ref_rd_bank;
        logic [PIPE_W-1:0] rd_pipe;
        logic [PIPE_W-1:0] wr_pipe;
        logic              drive;
        logic              capture;
        logic              term;
        logic              acc_strobe;
        access_type        acc;
        logic              load_strobe;
    } state_type;

    state_type         s;
    state_type         next_s;
    cmd_kind_type      kind;
    cmd_kind_type      issue_kind;
    logic [BANK_W-1:0] issue_bank;
    logic [ADDR_W-1:0] issue_addr;
    logic              ref_req;
    logic [BANK_W-1:0] ref_req_bank;
    logic [LAT_W-1:0]  lat;
    logic [ROW_W-1:0]  stored_row;

    // command sequencing, mode word, data timing and termination
    always_comb begin
        next_s             = s;
        next_s.acc_strobe  = 1'h0;
        next_s.load_strobe = 1'h0;
        next_s.ref_pending = 1'h0;
        kind               = decode_cmd(CMD);
        issue_kind         = NOP_CMD;
        issue_bank         = BANK;
        issue_addr         = ADDR;
        ref_req            = 1'h0;
        ref_req_bank       = s.ref_bank;
        lat                = read_lat(s.cfg);
        // a multiplexed refresh waits one edge, then runs
        if (s.ref_pending) begin
            ref_req = 1'h1;
        end
        unique case (s.phase)
            PHASE_IDLE: begin
                if (kind == ROW_REFRESH_CMD) begin
                    // only the bank matters, the address balls are ignored
                    if (s.mux) begin
                        next_s.ref_pending = 1'h1;
                        next_s.ref_bank    = BANK;
                    end else begin
                        ref_req      = 1'h1;
                        ref_req_bank = BANK;
                    end
                end else if (kind != NOP_CMD) begin
                    if (s.mux) begin
                        // keep command, bank and first half for one clock
                        next_s.phase      = PHASE_SECOND;
                        next_s.held_cmd   = kind;
                        next_s.held_bank  = BANK;
                        next_s.first_half = ADDR;
                    end else begin
                        issue_kind = kind;
                    end
                end
            end
            PHASE_SECOND: begin
                // second half arrives now; pins carry no new command
                issue_kind   = s.held_cmd;
                issue_bank   = s.held_bank;
                issue_addr   = map_mux_addr(s.first_half, ADDR, WIDTH, s.burst);
                next_s.phase = PHASE_IDLE;
            end
        endcase
        next_s.ref_rd      = ref_req;
        next_s.ref_rd_bank = ref_req_bank;
        // data pipes; a bit reaching the bottom marks one data clock
        next_s.rd_pipe = s.rd_pipe >> 1;
        next_s.wr_pipe = s.wr_pipe >> 1;
        unique case (issue_kind)
            READ_CMD, WRITE_CMD: begin
                next_s.acc_strobe = 1'h1;
                next_s.acc        = '{write: issue_kind == WRITE_CMD,
                                      bank:  issue_bank,
                                      addr:  issue_addr};
                // same count from the issuing edge in both modes, so the
                // multiplexed latency ends up one clock longer
                if (issue_kind == READ_CMD) begin
                    next_s.rd_pipe = next_s.rd_pipe
                                   | (beat_mask(s.burst) << (lat - LAT_ONE));
                end else begin
                    next_s.wr_pipe = next_s.wr_pipe
                                   | (beat_mask(s.burst) << lat);
                end
            end
            MODE_LOAD_CMD: begin
                next_s.load_strobe = 1'h1;
                next_s.cfg     = issue_addr[CFG_LSB +: CFG_W];
                next_s.burst   = burst_size_type'(issue_addr[BURST_LSB +: BURST_W]);
                next_s.mux     = issue_addr[MUX_BIT];
                next_s.term_en = issue_addr[TERM_BIT];
            end
            default: begin
            end
        endcase
        next_s.drive   = s.rd_pipe[0];
        next_s.capture = s.wr_pipe[0];
        // off one clock ahead of read data, on again after the last beat
        next_s.term = next_s.term_en & ~(next_s.rd_pipe[0] | next_s.drive);
    end

    // state register
    always_ff @(posedge CLK) begin
        if (RST) begin
            s         <= '0;
            s.phase   <= PHASE_IDLE;
            s.cfg     <= CFG_RESET;
            s.burst   <= BURST_2;
            s.mux     <= MUX_RESET;
            s.term_en <= TERM_RESET;
        end else begin
            s <= next_s;
        end
    end

    // per-bank refresh counters, fetched then advanced
    refresh_row_store #(
        .BANK_COUNT (BANKS),
        .ROW_BITS   (ROW_W)
    ) u_rows (
        .CLK     (CLK),
        .RST     (RST),
        .rd_en   (ref_req),
        .rd_bank (ref_req_bank),
        .rd_row  (stored_row),
        .wr_en   (s.ref_rd),
        .wr_bank (s.ref_rd_bank),
        .wr_row  (ROW_W'(stored_row + 1'h1))
    );

    // outputs
    assign REFRESH_STROBE    = s.ref_rd;
    assign REFRESH_BANK      = s.ref_rd_bank;
    assign REFRESH_ROW       = stored_row;
    assign ACCESS_STROBE     = s.acc_strobe;
    assign ACCESS            = s.acc;
    assign MODE_LOAD_STROBE  = s.load_strobe;
    assign CONFIG            = s.cfg;
    assign BURST_SIZE        = s.burst;
    assign MUX_MODE          = s.mux;
    assign READ_LATENCY      = LAT_W'(read_lat(s.cfg) + LAT_W'(s.mux));
    assign WRITE_LATENCY     = LAT_W'(read_lat(s.cfg) + LAT_ONE + LAT_W'(s.mux));
    assign READ_DRIVE        = s.drive;
    assign READ_VALID_FLAG   = s.drive;
    assign WRITE_CAPTURE     = s.capture;
    assign INPUT_TERMINATION = s.term;

    // checks
    sequence mux_access_start;
        s.phase == PHASE_IDLE && s.mux && (kind == READ_CMD || kind == WRITE_CMD);
    endsequence

    sequence second_half_taken;
        s.phase == PHASE_SECOND;
    endsequence

    a_refresh_normal: assert property (@(posedge CLK) disable iff (RST)
        s.phase == PHASE_IDLE && !s.mux && kind == ROW_REFRESH_CMD
        |=> REFRESH_STROBE && REFRESH_BANK == $past(BANK))
        else $error("normal refresh not run next clock");

    a_refresh_mux_delay: assert property (@(posedge CLK) disable iff (RST)
        s.phase == PHASE_IDLE && s.mux && kind == ROW_REFRESH_CMD
        |=> s.ref_pending ##1 REFRESH_STROBE && REFRESH_BANK == $past(BANK, 2))
        else $error("multiplexed refresh not run on next edge");

    a_term_load_bit: assert property (@(posedge CLK) disable iff (RST)
        issue_kind == MODE_LOAD_CMD |=> s.term_en == $past(issue_addr[TERM_BIT]))
        else $error("termination enable not loaded");

    a_term_read_off: assert property (@(posedge CLK) disable iff (RST)
        READ_DRIVE || s.rd_pipe[0] |-> !INPUT_TERMINATION)
        else $error("termination on while read data driven");

    a_term_back_on: assert property (@(posedge CLK) disable iff (RST)
        $fell(READ_DRIVE) && s.term_en && !s.rd_pipe[0] |-> INPUT_TERMINATION)
        else $error("termination not restored after read");

    a_mux_two_part: assert property (@(posedge CLK) disable iff (RST)
        mux_access_start ##1 second_half_taken |=> ACCESS_STROBE)
        else $error("multiplexed access not issued after second half");

    a_mux_addr_map: assert property (@(posedge CLK) disable iff (RST)
        second_half_taken && s.held_cmd != MODE_LOAD_CMD
        |=> ACCESS.addr[1] == $past(ADDR[3])
                              && ACCESS.addr[15] == $past(ADDR[18]))
        else $error("second half mapped to wrong bits");

    a_read_lat_normal: assert property (@(posedge CLK) disable iff (RST)
        s.phase == PHASE_IDLE && !s.mux && s.cfg == CFG_RESET && kind == READ_CMD
        |-> ##5 READ_DRIVE)
        else $error("normal read latency wrong");

    a_write_lat_normal: assert property (@(posedge CLK) disable iff (RST)
        s.phase == PHASE_IDLE && !s.mux && s.cfg == CFG_RESET && kind == WRITE_CMD
        |-> ##6 WRITE_CAPTURE)
        else $error("normal write latency wrong");

    a_read_lat_mux: assert property (@(posedge CLK) disable iff (RST)
        mux_access_start and (s.cfg == CFG_RESET && kind == READ_CMD)
        |-> ##6 READ_DRIVE)
        else $error("multiplexed read latency wrong");

    a_mux_entry: assert property (@(posedge CLK) disable iff (RST)
        issue_kind == MODE_LOAD_CMD |=> MUX_MODE == $past(issue_addr[MUX_BIT]))
        else $error("multiplexed mode bit not loaded");

endmodule : dram_refresh_odt_mux_address

// ---- dram_ctrl_model.sv ----
module dram_ctrl_model
    import dram_cmd_pkg::*;
(
    input  wire logic              CLK,  // command clock
    output      cmd_pins_type      CMD,  // command pins, low active
    output      logic [BANK_W-1:0] BANK, // bank balls
    output      logic [ADDR_W-1:0] ADDR  // address balls
);
    timeunit 1ns;
    timeprecision 1ps;

    // power up with no command and all address balls low
    initial begin
        CMD = 3'h7;
        BANK = 3'h0;
        ADDR = 21'h0;
    end

    // one command held for one edge; a second half follows on the next edge
    task automatic send(input cmd_pins_type      pins,
                        input logic [BANK_W-1:0] bank,
                        input logic [ADDR_W-1:0] first,
                        input logic [ADDR_W-1:0] second,
                        input logic              two_half);
        @(negedge CLK);
        CMD = pins;
        BANK = bank;
        ADDR = first;
        if (two_half) begin
            @(negedge CLK);
            CMD = 3'h7;
            ADDR = second;
        end
    endtask : send

    // release the balls; stale values are inverted so nothing can lean on them
    task automatic idle();
        @(negedge CLK);
        CMD = 3'h7;
        BANK = ~BANK;
        ADDR = ~ADDR;
    endtask : idle
endmodule : dram_ctrl_model

// ---- dram_refresh_odt_mux_address_test.sv ----
module dram_refresh_odt_mux_address_test import dram_cmd_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic       term;
        logic [1:0] burst;
        logic [2:0] cfg;
        logic [3:0] rl;
    } row_type;
    // mode word fields beside the read latency they select, burst 8 only in configs 2, 4
    localparam row_type ROWS [5] = '{'{1'h1, 2'h0, 3'h0, 4'h4}, '{1'h0, 2'h1, 3'h1, 4'h6},
                                     '{1'h1, 2'h2, 3'h2, 4'h8}, '{1'h1, 2'h1, 3'h3, 4'h3},
                                     '{1'h0, 2'h2, 3'h4, 4'h5}};
    localparam cmd_pins_type PINS [4] = '{3'h3, 3'h1, 3'h2, 3'h0};
    logic              clk, rst, mux, term_on;
    width_type         width;
    cmd_pins_type      cmd;
    logic [BANK_W-1:0] bank, ref_bank, rbank;
    logic [ADDR_W-1:0] addr;
    logic              ref_stb, acc_stb, mode_stb, rd_drive, rd_valid, wr_cap, term, mux_on;
    logic [ROW_W-1:0]  ref_row, rrow;
    logic [CFG_W-1:0]  cfg_now;
    burst_size_type    burst_now;
    logic [LAT_W-1:0]  rd_lat, wr_lat;
    access_type        acc_now, acc;
    logic [5:0]        twin = '0;
    int                rl, wl, beats, mismatches = 0, comparisons = 0;

    dram_refresh_odt_mux_address DUT (.CLK(clk), .RST(rst), .CMD(cmd), .BANK(bank),
        .ADDR(addr), .WIDTH(width), .REFRESH_STROBE(ref_stb), .REFRESH_BANK(ref_bank),
        .REFRESH_ROW(ref_row), .ACCESS_STROBE(acc_stb), .ACCESS(acc_now),
        .MODE_LOAD_STROBE(mode_stb), .CONFIG(cfg_now), .BURST_SIZE(burst_now),
        .MUX_MODE(mux_on), .READ_LATENCY(rd_lat), .WRITE_LATENCY(wr_lat),
        .READ_DRIVE(rd_drive), .READ_VALID_FLAG(rd_valid), .WRITE_CAPTURE(wr_cap),
        .INPUT_TERMINATION(term));
    dram_ctrl_model ctrl (.CLK(clk), .CMD(cmd), .BANK(bank), .ADDR(addr));

    // 50 MHz clock
    always #10 clk = ~clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want) begin
            mismatches++;
            $display("[FAIL] %0t seen %0h want %0h", $time, seen, want);
        end
    endtask : check

    task automatic stop_test();
        $display("TB: %0d mismatches in %0d comparisons", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test

    // per-cycle strobes and data-bus levels expected k cycles after a command
    function automatic logic [6:0] want_at(input int k, input int kind);
        int   at;
        logic rd;
        logic wr;
        at = mux ? 2 : 1;
        rd = kind == 0 && k > rl && k <= rl + beats;
        wr = kind == 1 && k > wl && k <= wl + beats;
        return {kind < 2 && k == at, kind == 2 && k == at, kind == 3 && k == at, rd, rd,
                term_on && !(kind == 0 && k >= rl && k <= rl + beats), wr};
    endfunction : want_at

    // issue one command (0 read, 1 write, 2 refresh, 3 mode) and trace up to cycle 15
    task automatic run(input int kind, input logic [2:0] bnk, input logic [20:0] first,
                       input logic [20:0] second);
        logic [6:0] seen [16];
        logic [6:0] mask;
        int         base;
        base = (mux && kind != 2) ? 2 : 1;
        mask = (kind == 3) ? 7'h7D : 7'h7F;
        ctrl.send(PINS[kind], bnk, first, second, base == 2);
        fork
            ctrl.idle();
            for (int k = base; k < 16; k++) begin
                @(posedge clk);
                #1;
                seen[k] = {acc_stb, ref_stb, mode_stb, rd_drive, rd_valid, term, wr_cap};
                if (acc_stb === 1'h1) acc = acc_now;
                if (ref_stb === 1'h1) {rbank, rrow} = {ref_bank, ref_row};
            end
        join
        for (int k = base; k < 16; k++) begin
            check(seen[k] & mask, want_at(k, kind) & mask);
        end
    endtask : run

    // bound on the whole run
    initial begin
        repeat (90000) @(posedge clk);
        mismatches++;
        stop_test();
    end

    // main sequence
    initial begin
        clk = 1'h0;
        rst = 1'h1;
        width = WIDTH_X36;
        mux = 1'h0;
        term_on = 1'h0;
        repeat (5) @(posedge clk);
        @(negedge clk);
        rst = 1'h0;
        @(negedge clk);
        check({ref_stb, acc_stb, mode_stb, rd_drive, wr_cap, term, mux_on, cfg_now, burst_now}, 0);
        foreach (ROWS[i]) begin
            run(3, 3'h0, {11'h0, ROWS[i].term, 4'h0, ROWS[i].burst, ROWS[i].cfg}, '0);
            rl = ROWS[i].rl;
            wl = rl + 1;
            beats = 1 << ROWS[i].burst;
            term_on = ROWS[i].term;
            check({cfg_now, burst_now, mux_on, term}, {ROWS[i].cfg, ROWS[i].burst, 1'h0, term_on});
            check({rd_lat, wr_lat}, {ROWS[i].rl, ROWS[i].rl + 4'h1});
            run(0, 3'(i), 21'h0ABCD + 21'(i), '0);
            check(acc, {1'h0, 3'(i), 21'h0ABCD + 21'(i)});
            run(1, 3'(i), 21'h15432, '0);
            check(acc, {1'h1, 3'(i), 21'h15432});
        end
        // refresh rows come from per-bank counters, address balls ignored
        run(2, 3'h3, 21'h1F0F0, '0);
        check({rbank, rrow}, {3'h3, 13'h0});
        run(2, 3'h3, 21'h0F0F0, '0);
        check({rbank, rrow}, {3'h3, 13'h1});
        run(2, 3'h5, 21'h1FFFF, '0);
        check({rbank, rrow}, {3'h5, 13'h0});
        // enter two-half addressing: config 0, burst 4, termination on
        run(3, 3'h0, 21'h000228, '0);
        mux = 1'h1;
        rl = 5;
        wl = 6;
        beats = 2;
        term_on = 1'h1;
        check({mux_on, rd_lat, wr_lat}, {1'h1, 4'h5, 4'h6});
        run(0, 3'h2, 21'h1FFFFF, 21'h0);
        check(acc, {1'h0, 3'h2, 21'h026739});
        run(1, 3'h4, 21'h0, 21'h066318);
        check(acc, {1'h1, 3'h4, 21'h0198C6});
        // two-half mode load: burst 2 on the narrow part
        width = WIDTH_X9;
        run(3, 3'h0, 21'h000220, 21'h0);
        beats = 1;
        run(0, 3'h1, 21'h0, 21'h000401);
        check(acc, {1'h0, 3'h1, 21'h180000});
        // refreshes on consecutive edges to different banks
        ctrl.send(PINS[2], 3'h1, '0, '0, 1'h0);
        fork
            begin
                ctrl.send(PINS[2], 3'h2, '0, '0, 1'h0);
                ctrl.idle();
            end
            for (int k = 1; k < 6; k++) begin
                @(posedge clk);
                #1;
                twin[k] = ref_stb;
            end
        join
        check(twin, 6'h0C);
        // rotate four banks so each is revisited after four clocks, every row once
        for (int i = 0; i < 8192; i++) begin
            for (int b = 4; b < 8; b++) ctrl.send(PINS[2], 3'(b), '0, '0, 1'h0);
        end
        ctrl.idle();
        run(2, 3'h7, 21'h15555, '0);
        check({rbank, rrow}, {3'h7, 13'h0});
        // reset in mid-run clears mode and counters
        @(negedge clk);
        rst = 1'h1;
        repeat (2) @(negedge clk);
        rst = 1'h0;
        check({mux_on, term, cfg_now, burst_now}, 0);
        mux = 1'h0;
        term_on = 1'h0;
        run(2, 3'h3, 21'h0, '0);
        check({rbank, rrow}, {3'h3, 13'h0});
        stop_test();
    end
endmodule : dram_refresh_odt_mux_address_test
